// ### src/wocb_map.svh
// Offsets, write mask, reset values and timing counts of the bank.
// Assumes inclusion by every design module and by the bench; the package does not include it.
`ifndef WOCB_MAP_SVH
`define WOCB_MAP_SVH

`define WOCB_ADDR_CLOCK_STOP      16'h001D
`define WOCB_ADDR_SYSTEM_PROTECT  16'h001F
`define WOCB_ADDR_CLOCK_OPTION    16'hFFCF
`define WOCB_AXI_CLOCK_STOP       8'h74
`define WOCB_AXI_SYSTEM_PROTECT   8'h7C
`define WOCB_AXI_CLOCK_OPTION     8'h80
`define WOCB_AXI_OPTION_PROGRAM   8'h84
`define WOCB_AXI_STATUS           8'h88
`define WOCB_RESET_VALUE          8'h00
`define WOCB_ERASED_VALUE         8'hFF
`define WOCB_CLOCK_STOP_MASK      8'hF9
`define WOCB_OPTION_PROG_KEY      8'hA5
`define WOCB_WDOG_SHORT_CYCLES    32'd8176
`define WOCB_WDOG_LONG_CYCLES     32'd262128
`define WOCB_RECOVERY_SHORT       13'd32
`define WOCB_RECOVERY_LONG        13'd4096
`define WOCB_RESP_OKAY            2'h0
`define WOCB_RESP_SLVERR          2'h2
`define WOCB_RESP_DECERR          2'h3

`endif

// ### src/wocb_pkg.sv
// Types shared by the option bank modules.
// Assumes the map header supplies all numeric constants.
package wocb_pkg;

    typedef struct packed {
        logic watchdog_rate_select;
        logic low_voltage_stop_enable;
        logic low_voltage_reset_disable;
        logic supply_detector_disable;
        logic regulator_detector_disable;
        logic short_recovery_select;
        logic stop_instruction_enable;
        logic watchdog_disable;
    } wocb_protect_type;

    typedef struct packed {
        logic       internal_osc_stop_disable;
        logic       rc_osc_stop_enable;
        logic       crystal_osc_stop_enable;
        logic [1:0] timebase_clock_select;
        logic [1:0] unused_zero;
        logic       serial_clock_source;
    } wocb_clock_stop_type;

    typedef enum logic [1:0] {
        WOCB_TB_INTERNAL,
        WOCB_TB_RC,
        WOCB_TB_CRYSTAL,
        WOCB_TB_NONE
    } wocb_timebase_type;

    typedef enum logic [1:0] {
        WOCB_BASE_NONE,
        WOCB_BASE_INTERNAL,
        WOCB_BASE_RC,
        WOCB_BASE_CRYSTAL
    } wocb_base_type;

    typedef struct packed {
        logic        watchdog_enable;
        logic [31:0] watchdog_timeout;
        logic        supply_monitor_on;
        logic        regulator_monitor_on;
        logic        inhibit_active_in_stop;
        logic        inhibit_reset_enable;
        logic [12:0] recovery_cycles;
        logic        stop_is_legal;
        logic        internal_osc_run_in_stop;
        logic        rc_osc_run_in_stop;
        logic        crystal_osc_run_in_stop;
        logic [1:0]  timebase_clock;
        logic        serial_from_bus_clock;
        logic [1:0]  base_clock;
    } wocb_controls_type;

endpackage

// ### src/wocb_once_reg.sv
// One write-once register with its own lock.
// Assumes a synchronous active-low reset on the bus clock.
`timescale 1ns/10ps
`include "wocb_map.svh"

module wocb_once_reg #(
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // State
    output logic      [7:0] value_q,
    output logic            locked_q
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_q <= `WOCB_RESET_VALUE;
        end else if (wr_en && !locked_q) begin
            value_q <= wr_data & WRITE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked_q <= 1'b0;
        end else if (wr_en) begin
            locked_q <= 1'b1;
        end
    end

    a_lock_holds_value: assert property (@(posedge aclk) disable iff (!aresetn)
        locked_q |=> $stable(value_q))
        else $error("locked register changed");

    a_reset_clears_reg: assert property (@(posedge aclk)
        !aresetn |=> (value_q == 8'h00 && !locked_q))
        else $error("reset did not clear register");

endmodule // wocb_once_reg

// ### src/wocb_option_bank.sv
// Write-once option bank with a flash-held clock option byte, AXI4-Lite.
// Assumes one bus clock, synchronous active-low reset, and a flash
// programmer that pulses the program strobe for the option byte.
`timescale 1ns/10ps
`include "wocb_map.svh"

module wocb_option_bank (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Flash programming of the option byte
    input  wire logic        option_program,
    input  wire logic [7:0]  option_program_data,
    input  wire logic        option_erase,
    // Stop-exit cause from the system
    input  wire logic        stop_exit_by_reset_pin,
    // Settings to the consuming modules
    output wocb_pkg::wocb_controls_type controls
);

    logic [7:0]  aw_addr_q;
    logic        aw_have_q;
    logic [7:0]  w_data_q;
    logic        w_strb0_q;
    logic        w_have_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_d;
    logic [1:0]  bresp_d;
    logic        wr_go;
    logic        wr_protect;
    logic        wr_clock_stop;
    logic [7:0]  protect_raw;
    logic [7:0]  clock_stop_raw;
    logic        protect_locked;
    logic        clock_stop_locked;
    logic [7:0]  option_q;
    // Power-up marker: the first edge loads the erased option byte
    logic        option_loaded_q = 1'b0;
    wocb_pkg::wocb_protect_type    prot;
    wocb_pkg::wocb_clock_stop_type cstop;

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q  <= 1'b1;
            w_data_q  <= s_axi_wdata[7:0];
            w_strb0_q <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    function automatic logic [1:0] wocb_decode_resp(input logic [7:0] a);
        case (a)
            `WOCB_AXI_CLOCK_STOP,
            `WOCB_AXI_SYSTEM_PROTECT,
            `WOCB_AXI_CLOCK_OPTION,
            `WOCB_AXI_STATUS:         wocb_decode_resp = `WOCB_RESP_OKAY;
            default:                  wocb_decode_resp = `WOCB_RESP_DECERR;
        endcase
    endfunction

    // Bus writes to the option byte are refused, not stored
    assign wr_protect    = wr_go && w_strb0_q
                           && aw_addr_q == `WOCB_AXI_SYSTEM_PROTECT;
    assign wr_clock_stop = wr_go && w_strb0_q
                           && aw_addr_q == `WOCB_AXI_CLOCK_STOP;

    always_comb begin
        bresp_d = wocb_decode_resp(aw_addr_q);
        if (aw_addr_q == `WOCB_AXI_CLOCK_OPTION
            || aw_addr_q == `WOCB_AXI_STATUS) begin
            bresp_d = `WOCB_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WOCB_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= bresp_d;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    wocb_once_reg #(
        .WRITE_MASK (8'hFF)
    ) u_protect (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_protect),
        .wr_data  (w_data_q),
        .value_q  (protect_raw),
        .locked_q (protect_locked)
    );

    wocb_once_reg #(
        .WRITE_MASK (`WOCB_CLOCK_STOP_MASK)
    ) u_clock_stop (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_clock_stop),
        .wr_data  (w_data_q),
        .value_q  (clock_stop_raw),
        .locked_q (clock_stop_locked)
    );

    assign prot  = protect_raw;
    assign cstop = clock_stop_raw;

    // Option byte: survives reset, changed only by the programmer
    always_ff @(posedge aclk) begin
        if (!option_loaded_q || option_erase) begin
            option_q <= `WOCB_ERASED_VALUE;
        end else if (option_program) begin
            option_q <= option_q & option_program_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!option_loaded_q) begin
            option_loaded_q <= 1'b1;
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rdata_d = 32'h00000000;
        rresp_d = wocb_decode_resp(s_axi_araddr);
        case (s_axi_araddr)
            `WOCB_AXI_SYSTEM_PROTECT: rdata_d[7:0] = protect_raw;
            `WOCB_AXI_CLOCK_STOP:     rdata_d[7:0] = clock_stop_raw;
            `WOCB_AXI_CLOCK_OPTION:   rdata_d[7:0] = option_q;
            `WOCB_AXI_STATUS:
                rdata_d[1:0] = {clock_stop_locked, protect_locked};
            default:                  rdata_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `WOCB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_d;
            s_axi_rresp  <= rresp_d;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Settings decode
    always_comb begin
        controls = '0;
        controls.watchdog_enable = !prot.watchdog_disable;
        controls.watchdog_timeout = prot.watchdog_rate_select
            ? `WOCB_WDOG_SHORT_CYCLES : `WOCB_WDOG_LONG_CYCLES;
        controls.supply_monitor_on =
            !prot.supply_detector_disable;
        controls.regulator_monitor_on =
            !prot.regulator_detector_disable;
        controls.inhibit_active_in_stop = prot.low_voltage_stop_enable
            && !(prot.supply_detector_disable
                 && prot.regulator_detector_disable);
        controls.inhibit_reset_enable =
            !prot.low_voltage_reset_disable;
        controls.recovery_cycles =
            (prot.short_recovery_select && !stop_exit_by_reset_pin)
            ? `WOCB_RECOVERY_SHORT : `WOCB_RECOVERY_LONG;
        controls.stop_is_legal = prot.stop_instruction_enable;
        controls.internal_osc_run_in_stop =
            !cstop.internal_osc_stop_disable;
        controls.rc_osc_run_in_stop = cstop.rc_osc_stop_enable;
        controls.crystal_osc_run_in_stop =
            cstop.crystal_osc_stop_enable;
        controls.timebase_clock = cstop.timebase_clock_select;
        controls.serial_from_bus_clock =
            cstop.serial_clock_source;
        controls.base_clock = option_q[7:6];
    end

    a_reset_pin_long: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_exit_by_reset_pin |-> controls.recovery_cycles == 13'd4096)
        else $error("reset pin exit not long recovery");

    a_short_recovery: assert property (@(posedge aclk) disable iff (!aresetn)
        (protect_raw[2] && !stop_exit_by_reset_pin)
        |-> controls.recovery_cycles == 13'd32)
        else $error("short recovery not applied");

    a_one_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_protect && protect_locked) |=> $stable(protect_raw))
        else $error("second write changed register");

    a_locks_separate: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_protect && !wr_clock_stop && !clock_stop_locked)
        |=> !clock_stop_locked)
        else $error("lock leaked to other register");

    a_zero_bits_read: assert property (@(posedge aclk) disable iff (!aresetn)
        clock_stop_raw[2:1] == 2'b00)
        else $error("reserved bits not zero");

    a_watchdog_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        controls.watchdog_timeout == (protect_raw[7] ? 32'd8176
                                                     : 32'd262128))
        else $error("watchdog timeout wrong");

    a_option_no_bus: assert property (@(posedge aclk)
        (option_loaded_q && !option_program && !option_erase)
        |=> $stable(option_q))
        else $error("option byte changed without programming");

    a_read_returns: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready
         && s_axi_araddr == 8'h7C && !wr_protect)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == protect_raw)
        else $error("read data mismatch");

    a_stop_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
        (protect_raw[6] && !protect_raw[4])
        |-> controls.inhibit_active_in_stop)
        else $error("inhibit not kept in stop");

endmodule // wocb_option_bank

// ### tb/wocb_option_bank_bench.sv
// Self-checking bench for the write-once option bank.
// Assumes the design package and map header compile first.
`timescale 1ns/10ps
`include "wocb_map.svh"

module wocb_option_bank_bench;

    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        option_program;
    logic [7:0]  option_program_data;
    logic        option_erase;
    logic        stop_exit_by_reset_pin;
    wocb_pkg::wocb_controls_type controls;
    int          error_cnt;
    int          total_checks;
    int          cycle_cnt;
    logic [7:0]  vals [4] = '{8'hA5, 8'h7A, 8'h48, 8'h2E};
    logic [7:0]  pv;
    logic [7:0]  cv;

    wocb_option_bank dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .option_program(option_program),
        .option_program_data(option_program_data),
        .option_erase(option_erase),
        .stop_exit_by_reset_pin(stop_exit_by_reset_pin),
        .controls(controls)
    );

    always #10 aclk = ~aclk;

    task automatic print_verdict;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                             input logic [3:0] strb, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
    endtask

    task automatic flash(input logic prog, input logic er,
                         input logic [7:0] d);
        option_program <= prog;
        option_erase <= er;
        option_program_data <= d;
        @(posedge aclk);
        option_program <= 1'b0;
        option_erase <= 1'b0;
        @(posedge aclk);
    endtask

    // Expected outputs from the protect, clock-stop and option bytes
    function automatic wocb_pkg::wocb_controls_type exp_ctl(
        input logic [7:0] p, input logic [7:0] c, input logic [7:0] o,
        input logic pin);
        wocb_pkg::wocb_controls_type e;
        e.watchdog_enable = !p[0];
        e.watchdog_timeout = p[7] ? 32'h00001FF0 : 32'h0003FFF0;
        e.supply_monitor_on = !p[4];
        e.regulator_monitor_on = !p[3];
        e.inhibit_active_in_stop = p[6] && !(p[4] && p[3]);
        e.inhibit_reset_enable = !p[5];
        e.recovery_cycles = (p[2] && !pin) ? 13'h0020 : 13'h1000;
        e.stop_is_legal = p[1];
        e.internal_osc_run_in_stop = !c[7];
        e.rc_osc_run_in_stop = c[6];
        e.crystal_osc_run_in_stop = c[5];
        e.timebase_clock = c[4:3];
        e.serial_from_bus_clock = c[0];
        e.base_clock = o[7:6];
        return e;
    endfunction

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        option_program = 1'b0;
        option_program_data = 8'h00;
        option_erase = 1'b0;
        stop_exit_by_reset_pin = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        cycle_cnt = 0;
        do_reset();
        axi_read(`WOCB_AXI_CLOCK_STOP, 32'h0, `WOCB_RESP_OKAY);
        axi_read(`WOCB_AXI_SYSTEM_PROTECT, 32'h0, `WOCB_RESP_OKAY);
        axi_read(`WOCB_AXI_CLOCK_OPTION, 32'hFF, `WOCB_RESP_OKAY);
        check(controls, exp_ctl(8'h00, 8'h00, 8'hFF, 1'b0));
        // Strobe-less write neither stores nor locks
        axi_write(`WOCB_AXI_SYSTEM_PROTECT, 8'hFF, 4'h0,
                  `WOCB_RESP_OKAY);
        axi_read(`WOCB_AXI_STATUS, 32'h0, `WOCB_RESP_OKAY);
        axi_write(8'h40, 8'h12, 4'hF, `WOCB_RESP_DECERR);
        axi_read(8'h40, 32'h0, `WOCB_RESP_DECERR);
        axi_write(`WOCB_AXI_CLOCK_OPTION, 8'h00, 4'hF,
                  `WOCB_RESP_SLVERR);
        axi_read(`WOCB_AXI_CLOCK_OPTION, 32'hFF, `WOCB_RESP_OKAY);
        // Internal oscillator base clock, so short recovery may be set
        flash(1'b1, 1'b0, 8'h7F);
        axi_read(`WOCB_AXI_CLOCK_OPTION, 32'h7F, `WOCB_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            pv = vals[i];
            cv = vals[3 - i];
            do_reset();
            axi_read(`WOCB_AXI_STATUS, 32'h0, `WOCB_RESP_OKAY);
            axi_write(`WOCB_AXI_SYSTEM_PROTECT, pv, 4'hF,
                      `WOCB_RESP_OKAY);
            axi_read(`WOCB_AXI_STATUS, 32'h1, `WOCB_RESP_OKAY);
            axi_write(`WOCB_AXI_SYSTEM_PROTECT, ~pv, 4'hF,
                      `WOCB_RESP_OKAY);
            axi_read(`WOCB_AXI_SYSTEM_PROTECT, {24'h0, pv},
                     `WOCB_RESP_OKAY);
            axi_write(`WOCB_AXI_CLOCK_STOP, cv, 4'hF,
                      `WOCB_RESP_OKAY);
            axi_write(`WOCB_AXI_CLOCK_STOP, ~cv, 4'hF,
                      `WOCB_RESP_OKAY);
            axi_read(`WOCB_AXI_CLOCK_STOP, {24'h0, cv & 8'hF9},
                     `WOCB_RESP_OKAY);
            axi_read(`WOCB_AXI_STATUS, 32'h3, `WOCB_RESP_OKAY);
            check(controls, exp_ctl(pv, cv, 8'h7F, 1'b0));
            check(controls.base_clock, 2'h1);
            stop_exit_by_reset_pin <= 1'b1;
            @(posedge aclk);
            check(controls, exp_ctl(pv, cv, 8'h7F, 1'b1));
            stop_exit_by_reset_pin <= 1'b0;
        end
        // Option byte: program clears bits only, erase restores ones
        flash(1'b1, 1'b0, 8'h7F);
        axi_read(`WOCB_AXI_CLOCK_OPTION, 32'h7F, `WOCB_RESP_OKAY);
        check(controls, exp_ctl(pv, cv, 8'h7F, 1'b0));
        flash(1'b1, 1'b0, 8'hBF);
        check(controls, exp_ctl(pv, cv, 8'h3F, 1'b0));
        flash(1'b0, 1'b1, 8'h00);
        flash(1'b1, 1'b0, 8'hBF);
        do_reset();
        axi_read(`WOCB_AXI_CLOCK_OPTION, 32'hBF, `WOCB_RESP_OKAY);
        check(controls, exp_ctl(8'h00, 8'h00, 8'hBF, 1'b0));
        print_verdict();
    end

endmodule // wocb_option_bank_bench
